/* hw/pin_mux_pkg.sv */
package pin_mux_pkg;

    // serial word: address field above data field, sent msb first
    localparam int unsigned ADDR_BITS = 4;
    localparam int unsigned DATA_BITS = 12;
    localparam int unsigned WORD_BITS = ADDR_BITS + DATA_BITS;

    // configuration register address
    localparam logic [ADDR_BITS-1:0] CFG_ADDR = 4'h0;

    // field positions inside the configuration register
    localparam int unsigned FMT_BIT = 0;
    localparam int unsigned OEA_BIT = 1;
    localparam int unsigned PD_BIT  = 2;

    // reset value: offset binary, channel A driving, normal operation
    localparam logic [DATA_BITS-1:0] CFG_RESET = 12'h000;

    // pin levels
    localparam logic FMT_TWOS      = 1'b1;
    localparam logic FMT_OFFSET    = 1'b0;
    localparam logic OE_PIN_ENABLE = 1'b0;
    localparam logic PD_ACTIVE     = 1'b1;
    localparam logic PD_NORMAL     = 1'b0;
    localparam logic SEL_STATIC    = 1'b0;

    // synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        MODE_STATIC = 2'b01,
        MODE_SERIAL = 2'b10
    } mode_t;

endpackage : pin_mux_pkg

/* hw/serial_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface serial_cfg_if;
    logic                                 active;
    logic                                 sclk_rise;
    logic                                 enable_n;
    logic                                 data;
    logic                                 write_strobe;
    logic [pin_mux_pkg::ADDR_BITS-1:0]    write_addr;
    logic [pin_mux_pkg::DATA_BITS-1:0]    write_data;
    logic                                 frame_error;

    modport port (
        input  active,
        input  sclk_rise,
        input  enable_n,
        input  data,
        output write_strobe,
        output write_addr,
        output write_data,
        output frame_error
    );

    modport core (
        output active,
        output sclk_rise,
        output enable_n,
        output data,
        input  write_strobe,
        input  write_addr,
        input  write_data,
        input  frame_error
    );
endinterface : serial_cfg_if

`default_nettype wire

/* hw/serial_cfg_port.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_cfg_port (
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // shifter side
    serial_cfg_if.port     sif
);
    localparam int unsigned CNT_W = $clog2(pin_mux_pkg::WORD_BITS + 2);
    localparam logic [CNT_W-1:0] FULL = CNT_W'(pin_mux_pkg::WORD_BITS);

    logic [pin_mux_pkg::WORD_BITS-1:0] shift;
    logic [CNT_W-1:0]                  count;
    logic                              in_frame;
    logic                              overflow;
    logic                              frame_end;

    // frame ends on enable release or on going inactive; a frame cut short by going inactive never writes
    assign frame_end = in_frame && (sif.enable_n || !sif.active);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= sif.active && !sif.enable_n;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift    <= '0;
            count    <= '0;
            overflow <= 1'b0;
        end else if (!sif.active || sif.enable_n) begin
            count    <= '0;
            overflow <= 1'b0;
        end else if (sif.sclk_rise) begin
            shift <= {shift[pin_mux_pkg::WORD_BITS-2:0], sif.data};
            if (count == FULL) begin
                overflow <= 1'b1;
            end else begin
                count <= count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sif.write_strobe <= 1'b0;
            sif.frame_error  <= 1'b0;
            sif.write_addr   <= '0;
            sif.write_data   <= '0;
        end else begin
            // a short or long frame is dropped and flagged
            sif.write_strobe <= frame_end && sif.active && count == FULL && !overflow;
            sif.frame_error  <= frame_end && (count != FULL || overflow);
            if (frame_end) begin
                sif.write_addr <= shift[pin_mux_pkg::WORD_BITS-1:pin_mux_pkg::DATA_BITS];
                sif.write_data <= shift[pin_mux_pkg::DATA_BITS-1:0];
            end
        end
    end

    // the shifter needs room for at least two bits
    if (pin_mux_pkg::WORD_BITS < 2) begin : g_bad_word
        $error("serial word too short");
    end
endmodule : serial_cfg_port

`default_nettype wire

/* hw/adc_control_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_control_pin_mux (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // host pins
    input  wire logic   interface_select,
    input  wire logic   shared_pin_fmt_sen,
    input  wire logic   shared_pin_oea_sclk,
    input  wire logic   shared_pin_pd_serial_write_data,
    input  wire logic   chan_b_output_enable_n,
    // converter over-range detectors
    input  wire logic   chan_a_overrange_in,
    input  wire logic   chan_b_overrange_in,
    // converter controls
    output logic        output_format_twos,
    output logic        chan_a_data_oe,
    output logic        chan_b_data_oe,
    output logic        power_down,
    // over-range pins
    output logic        chan_a_overrange_flag,
    output logic        chan_b_overrange_flag,
    // status
    output logic        serial_mode,
    output logic        cfg_write_done,
    output logic        cfg_frame_error
);
    localparam int unsigned NPIN = 5;
    localparam int unsigned P_SEL = 0;
    localparam int unsigned P_A   = 1;
    localparam int unsigned P_B   = 2;
    localparam int unsigned P_C   = 3;
    localparam int unsigned P_OEB = 4;

    logic [NPIN-1:0] pins_raw;
    logic [NPIN-1:0] sync_meta;
    logic [NPIN-1:0] sync_pin;
    logic            sclk_prev;

    pin_mux_pkg::mode_t              mode;
    pin_mux_pkg::mode_t              next_mode;
    logic [pin_mux_pkg::DATA_BITS-1:0] cfg;

    logic next_format;
    logic next_oea_pin;
    logic next_pd;

    serial_cfg_if sif ();

    // the logic below is built for exactly these package values
    if (pin_mux_pkg::SYNC_STAGES != 2) begin : g_bad_sync
        $error("two synchroniser stages are built in");
    end
    if (pin_mux_pkg::PD_BIT >= pin_mux_pkg::DATA_BITS) begin : g_bad_field
        $error("configuration field outside the register");
    end

    // a finished frame aimed at the configuration register
    function automatic logic cfg_hit(
        input logic                              strobe,
        input logic [pin_mux_pkg::ADDR_BITS-1:0] addr
    );
        return strobe && (addr == pin_mux_pkg::CFG_ADDR);
    endfunction : cfg_hit

    // enable pins are active low
    function automatic logic pin_enables(input logic pin);
        return pin == pin_mux_pkg::OE_PIN_ENABLE;
    endfunction : pin_enables

    assign pins_raw[P_SEL] = interface_select;
    assign pins_raw[P_A]   = shared_pin_fmt_sen;
    assign pins_raw[P_B]   = shared_pin_oea_sclk;
    assign pins_raw[P_C]   = shared_pin_pd_serial_write_data;
    assign pins_raw[P_OEB] = chan_b_output_enable_n;

    // two-stage synchroniser on every host pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_meta <= '0;
        end else begin
            sync_meta <= pins_raw;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_pin <= '0;
        end else begin
            sync_pin <= sync_meta;
        end
    end

    // serial clock edge detect on the settled copy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= sync_pin[P_B];
        end
    end

    // mode follows the select level
    always_comb begin
        if (sync_pin[P_SEL] == pin_mux_pkg::SEL_STATIC) begin
            next_mode = pin_mux_pkg::MODE_STATIC;
        end else begin
            next_mode = pin_mux_pkg::MODE_SERIAL;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode <= pin_mux_pkg::MODE_STATIC;
        end else begin
            mode <= next_mode;
        end
    end

    // serial port only sees the pins while serial mode holds
    assign sif.active    = (mode == pin_mux_pkg::MODE_SERIAL) && sync_pin[P_SEL];
    assign sif.sclk_rise = sync_pin[P_B] && !sclk_prev;
    assign sif.enable_n  = sync_pin[P_A];
    assign sif.data      = sync_pin[P_C];

    serial_cfg_port u_port (
        .clk (clk),
        .rst (rst),
        .sif (sif.port)
    );

    // write-only configuration register, cleared while select is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= pin_mux_pkg::CFG_RESET;
        end else if (sync_pin[P_SEL] == pin_mux_pkg::SEL_STATIC) begin
            cfg <= pin_mux_pkg::CFG_RESET;
        end else if (cfg_hit(sif.write_strobe, sif.write_addr)) begin
            cfg <= sif.write_data;
        end
    end

    // choose where the three controls come from
    always_comb begin
        unique case (mode)
            pin_mux_pkg::MODE_STATIC: begin
                next_format  = sync_pin[P_A];
                next_oea_pin = sync_pin[P_B];
                next_pd      = sync_pin[P_C];
            end
            pin_mux_pkg::MODE_SERIAL: begin
                next_format  = cfg[pin_mux_pkg::FMT_BIT];
                next_oea_pin = cfg[pin_mux_pkg::OEA_BIT];
                next_pd      = cfg[pin_mux_pkg::PD_BIT];
            end
            default: begin
                next_format  = pin_mux_pkg::FMT_OFFSET;
                next_oea_pin = pin_mux_pkg::OE_PIN_ENABLE;
                next_pd      = pin_mux_pkg::PD_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            output_format_twos <= pin_mux_pkg::FMT_OFFSET;
        end else begin
            output_format_twos <= (next_format == pin_mux_pkg::FMT_TWOS);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_a_data_oe <= 1'b1;
            chan_b_data_oe <= 1'b1;
        end else begin
            chan_a_data_oe <= pin_enables(next_oea_pin);
            chan_b_data_oe <= pin_enables(sync_pin[P_OEB]);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_down <= pin_mux_pkg::PD_NORMAL;
        end else begin
            power_down <= (next_pd == pin_mux_pkg::PD_ACTIVE);
        end
    end

    // each flag follows its own channel only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_a_overrange_flag <= 1'b0;
            chan_b_overrange_flag <= 1'b0;
        end else begin
            chan_a_overrange_flag <= chan_a_overrange_in;
            chan_b_overrange_flag <= chan_b_overrange_in;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_mode     <= 1'b0;
            cfg_write_done  <= 1'b0;
            cfg_frame_error <= 1'b0;
        end else begin
            serial_mode     <= (mode == pin_mux_pkg::MODE_SERIAL);
            cfg_write_done  <= cfg_hit(sif.write_strobe, sif.write_addr);
            cfg_frame_error <= sif.frame_error;
        end
    end

endmodule : adc_control_pin_mux

`default_nettype wire

/* bench/pin_mux_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    input wire logic interface_select,
    input wire logic shared_pin_fmt_sen,
    input wire logic shared_pin_oea_sclk,
    input wire logic shared_pin_pd_serial_write_data,
    input wire logic chan_b_output_enable_n,
    input wire logic chan_a_overrange_in,
    input wire logic chan_b_overrange_in,
    // outputs
    input wire logic output_format_twos,
    input wire logic chan_a_data_oe,
    input wire logic chan_b_data_oe,
    input wire logic power_down,
    input wire logic chan_a_overrange_flag,
    input wire logic chan_b_overrange_flag,
    input wire logic serial_mode,
    input wire logic cfg_write_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_ovr;
        !$past(rst) |-> {chan_a_overrange_flag, chan_b_overrange_flag}
            == $past({chan_a_overrange_in, chan_b_overrange_in});
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrange flag mismatch");
    property p_oeb;
        $stable(chan_b_output_enable_n) [*5] |-> chan_b_data_oe == !chan_b_output_enable_n;
    endproperty
    a_oeb: assert property (p_oeb) else $error("chan b enable wrong");
    property p_fmt;
        (!serial_mode && $stable(shared_pin_fmt_sen)) [*6]
            |-> output_format_twos == shared_pin_fmt_sen;
    endproperty
    a_fmt: assert property (p_fmt) else $error("format wrong");
    property p_oea;
        (!serial_mode && $stable(shared_pin_oea_sclk)) [*6]
            |-> chan_a_data_oe == !shared_pin_oea_sclk;
    endproperty
    a_oea: assert property (p_oea) else $error("chan a enable wrong");
    property p_pd;
        (!serial_mode && $stable(shared_pin_pd_serial_write_data)) [*6] |-> power_down == shared_pin_pd_serial_write_data;
    endproperty
    a_pd: assert property (p_pd) else $error("power down wrong");
    property p_sel_lo;
        (!interface_select) [*5] |-> !serial_mode && !cfg_write_done;
    endproperty
    a_sel_lo: assert property (p_sel_lo) else $error("serial active in static");
    property p_sel_hi;
        interface_select [*5] |-> serial_mode;
    endproperty
    a_sel_hi: assert property (p_sel_hi) else $error("serial mode missing");
    property p_hold;
        serial_mode && $past(serial_mode, 3) && !$past(cfg_write_done)
            && !$past(cfg_write_done, 2)
            |-> $stable({output_format_twos, chan_a_data_oe, power_down});
    endproperty
    a_hold: assert property (p_hold) else $error("serial setting moved");
    property p_entry;
        $rose(serial_mode) |-> ##[1:2] (!output_format_twos && chan_a_data_oe && !power_down);
    endproperty
    a_entry: assert property (p_entry) else $error("config not cleared");
    c_write: cover property (cfg_write_done);
    c_enter: cover property ($rose(serial_mode));
    c_leave: cover property ($fell(serial_mode));
endmodule : pin_mux_checker
bind adc_control_pin_mux pin_mux_checker chk_u (.clk, .rst, .interface_select,
    .shared_pin_fmt_sen, .shared_pin_oea_sclk, .shared_pin_pd_serial_write_data,
    .chan_b_output_enable_n, .chan_a_overrange_in, .chan_b_overrange_in,
    .output_format_twos, .chan_a_data_oe, .chan_b_data_oe, .power_down,
    .chan_a_overrange_flag, .chan_b_overrange_flag, .serial_mode, .cfg_write_done);
`default_nettype wire

/* bench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock
    input wire logic clk,
    // pins
    output logic     sel,
    output logic     fmt_sen,
    output logic     oea_sclk,
    output logic     pd_serial_write_data,
    output logic     oeb_n
);
    initial begin
        sel = 1'b0;
        fmt_sen = 1'b0;
        oea_sclk = 1'b0;
        pd_serial_write_data = 1'b0;
        oeb_n = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_n
    task automatic set_static(input logic f, input logic a, input logic p, input logic b);
        @(posedge clk);
        sel <= 1'b0;
        fmt_sen <= f;
        oea_sclk <= a;
        pd_serial_write_data <= p;
        oeb_n <= b;
    endtask : set_static
    task automatic sel_pulse();
        @(posedge clk);
        sel <= 1'b0;
        fmt_sen <= 1'b1;
        oea_sclk <= 1'b0;
        wait_n(4);
        sel <= 1'b1;
        wait_n(4);
    endtask : sel_pulse
    // write-only frame, msb first, clock idles low
    task automatic write(input logic [15:0] w, input int n);
        @(posedge clk);
        fmt_sen <= 1'b0;
        for (int i = 0; i < n; i++) begin
            pd_serial_write_data <= w[15-i];
            wait_n(4);
            oea_sclk <= 1'b1;
            wait_n(4);
            oea_sclk <= 1'b0;
        end
        wait_n(4);
        fmt_sen <= 1'b1;
        pd_serial_write_data <= ~pd_serial_write_data;
        wait_n(4);
    endtask : write
endmodule : host_model
`default_nettype wire

/* bench/adc_control_pin_mux_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_control_pin_mux_tb_top;
    logic clk, rst, ovr_a, ovr_b, look, sel, fmt_sen, oea_sclk, pd_serial_write_data, oeb_n;
    logic fmt, oe_a, oe_b, pd, smode, done, ferr;
    logic flag_a, flag_b, rst_d;
    logic [1:0] ovr_hist;
    logic [3:0] exp_q[$];
    logic [3:0] e, r;
    int fails = 0;
    int samples_checked = 0;
    int done_n = 0;
    int err_n = 0;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    adc_control_pin_mux dut_u (.clk(clk), .rst(rst), .interface_select(sel),
        .shared_pin_fmt_sen(fmt_sen), .shared_pin_oea_sclk(oea_sclk),
        .shared_pin_pd_serial_write_data(pd_serial_write_data), .chan_b_output_enable_n(oeb_n),
        .chan_a_overrange_in(ovr_a), .chan_b_overrange_in(ovr_b),
        .output_format_twos(fmt), .chan_a_data_oe(oe_a), .chan_b_data_oe(oe_b),
        .power_down(pd), .chan_a_overrange_flag(flag_a), .chan_b_overrange_flag(flag_b),
        .serial_mode(smode), .cfg_write_done(done), .cfg_frame_error(ferr));
    host_model host_u (.clk(clk), .sel(sel), .fmt_sen(fmt_sen), .oea_sclk(oea_sclk),
        .pd_serial_write_data(pd_serial_write_data), .oeb_n(oeb_n));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // note {format, a enable, b enable, power down} once pins have settled
    task automatic expect_out(input logic [3:0] want);
        host_u.wait_n(8);
        exp_q.push_back(want);
        look <= 1'b1;
        host_u.wait_n(1);
        look <= 1'b0;
    endtask : expect_out
    always @(posedge clk) begin
        if (look === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check({12'h000, fmt, oe_a, oe_b, pd}, {12'h000, e});
        end
        if (done === 1'b1) done_n++;
        if (ferr === 1'b1) err_n++;
        // flags copy the inputs seen one edge before
        if (rst === 1'b0 && rst_d === 1'b0) begin
            check({14'h0000, flag_a, flag_b}, {14'h0000, ovr_hist});
        end
        rst_d <= rst;
        ovr_hist <= {ovr_a, ovr_b};
        ovr_a <= 1'($urandom());
        ovr_b <= 1'($urandom());
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(87705));
        rst = 1'b1;
        look = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        expect_out(4'h6);
        for (int k = 0; k < 8; k++) begin
            r = 4'($urandom());
            host_u.set_static(r[3], r[2], r[1], r[0]);
            expect_out({r[3], ~r[2], ~r[0], r[1]});
        end
        host_u.set_static(1'b1, 1'b1, 1'b1, 1'b1);
        expect_out(4'h9);
        host_u.sel_pulse();
        expect_out(4'h4);
        check({15'h0000, smode}, 16'h0001);
        host_u.write(16'h0005, 16);
        expect_out(4'hD);
        host_u.write(16'h0007, 15);
        expect_out(4'hD);
        check(16'(err_n), 16'h0001);
        host_u.write(16'h1002, 16);
        host_u.write(16'h0002, 16);
        expect_out(4'h0);
        check(16'(done_n), 16'h0002);
        host_u.sel_pulse();
        expect_out(4'h4);
        host_u.set_static(1'b0, 1'b0, 1'b0, 1'b1);
        expect_out(4'h4);
        check({15'h0000, smode}, 16'h0000);
        host_u.write(16'h0007, 16);
        expect_out(4'hC);
        check(16'(done_n), 16'h0002);
        tally_and_finish();
    end
endmodule : adc_control_pin_mux_tb_top
`default_nettype wire
